/* File: design/iopw_top.sv */
// io pins, indicator leds and host watchdog behind a wishbone slave
// Notes on behaviour
// R01 - input pin: undriven, pulled up, level reported, output value ignored
// R02 - push-pull output drives host value, inverted if selected
// R03 - open-drain: zero pulls low, one releases, pin level reads back
// R04 - drain and invert settings only matter while the pin is an output
// R05 - free pins fully configurable at run time
// R06 - claimed pins follow module direction; only drain and invert apply
// R07 - true and complemented sensed level reported for every pin
// R08 - one host bit per led; one lights it
// R09 - watchdog sleeps until first host access
// R10 - watchdog bites when service gap exceeds programmed ns timeout
// R11 - host services watchdog; each service restarts full timeout
// R12 - on bite all pins become pulled-up inputs, host traffic stops; the code still acks, status stays readable and clearable
// R13 - bite leaves module state alone; only pin connection changes
// R14 - bitten flag reads true after a bite, false otherwise
// R15 - host clears bitten flag; traffic resumes, pins back to load config
// R16 - timeout converted to clock cycles, decremented, bites at zero
module iopw_top
  import iopw_pkg::*;
#(
  parameter logic [31:0] BITE_BITE_TIMEOUT = IOPW_BITE_TIMEOUT
) (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // function modules
  input  wire logic [IOPW_NPINS-1:0] mod_claim,
  input  wire logic [IOPW_NPINS-1:0] mod_dir,
  input  wire logic [IOPW_NPINS-1:0] mod_out,
  output logic      [IOPW_NPINS-1:0] mod_in,
  // pads
  input  wire logic [IOPW_NPINS-1:0] pin_i,
  output logic      [IOPW_NPINS-1:0] pin_o,
  output logic      [IOPW_NPINS-1:0] pin_oe_n,
  // board
  output logic      [IOPW_NLEDS-1:0] led_o,
  output logic                       wd_bitten
);

  // ****************************************
  // declarations
  // ****************************************
  logic                  ack_q;
  logic                  ack_d;
  logic [31:0]           rdat_q;
  logic [31:0]           rdat_d;
  iopw_cfg_s             cfg_q;
  iopw_cfg_s             cfg_d;
  logic [IOPW_NLEDS-1:0] led_q;
  logic [IOPW_NLEDS-1:0] led_d;
  logic [31:0]           tmo_q;
  logic [31:0]           tmo_d;
  logic [IOPW_NPINS-1:0] in_q;
  logic [IOPW_NPINS-1:0] pin_o_q;
  logic [IOPW_NPINS-1:0] pin_o_d;
  logic [IOPW_NPINS-1:0] oe_n_q;
  logic [IOPW_NPINS-1:0] oe_n_d;
  logic [IOPW_NPINS-1:0] eff_dir;
  logic [IOPW_NPINS-1:0] eff_val;
  logic [IOPW_NPINS-1:0] drv;
  logic                  req;
  logic                  take;
  logic                  wr_ok;
  logic                  wd_awake;
  logic                  wd_pet;
  logic                  wd_clear;
  logic [31:0]           wd_cycles;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    return adr[7:2] == off[7:2];
  endfunction

  // ****************************************
  // bus handshake
  // ****************************************
  assign req   = wb_cyc_i && wb_stb_i;
  assign take  = req && ack_q;
  assign wr_ok = take && wb_we_i && !wd_bitten; // R12

  // status stays reachable while bitten, or nobody could recover
  assign wd_clear = take && wb_we_i && hit(wb_adr_i, IOPW_OFF_STATUS) &&
                    wb_sel_i[0] && !wb_dat_i[IOPW_ST_BITTEN]; // R15
  assign wd_pet   = wr_ok && hit(wb_adr_i, IOPW_OFF_SERVICE); // R11
  assign wd_cycles = iopw_ns_to_cycles(tmo_q); // R16

  always_comb begin
    ack_d  = req && !ack_q;
    rdat_d = rdat_q;
    if (req && !ack_q) begin
      rdat_d = 32'h0;
      if (hit(wb_adr_i, IOPW_OFF_STATUS)) begin
        rdat_d[IOPW_ST_BITTEN] = wd_bitten; // R14
        rdat_d[IOPW_ST_AWAKE]  = wd_awake;
      end else if (!wd_bitten) begin
        if (hit(wb_adr_i, IOPW_OFF_DIR)) begin
          rdat_d[IOPW_NPINS-1:0] = cfg_q.dir;
        end else if (hit(wb_adr_i, IOPW_OFF_DRAIN)) begin
          rdat_d[IOPW_NPINS-1:0] = cfg_q.drain;
        end else if (hit(wb_adr_i, IOPW_OFF_INV)) begin
          rdat_d[IOPW_NPINS-1:0] = cfg_q.inv;
        end else if (hit(wb_adr_i, IOPW_OFF_OUT)) begin
          rdat_d[IOPW_NPINS-1:0] = cfg_q.out;
        end else if (hit(wb_adr_i, IOPW_OFF_IN)) begin
          rdat_d[IOPW_NPINS-1:0] = in_q; // R07
          rdat_d[IOPW_IN_NOT_LSB +: IOPW_NPINS] = ~in_q; // R07
        end else if (hit(wb_adr_i, IOPW_OFF_LED)) begin
          rdat_d[IOPW_NLEDS-1:0] = led_q;
        end else if (hit(wb_adr_i, IOPW_OFF_TIMEOUT)) begin
          rdat_d = tmo_q;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ****************************************
  // register writes
  // ****************************************
  always_comb begin
    cfg_d = cfg_q;
    led_d = led_q;
    tmo_d = tmo_q;
    if (wd_bitten) begin
      // load-time settings are parked here so recovery restores them
      cfg_d = IOPW_CFG_RST; // R15
    end else if (wr_ok) begin
      if (hit(wb_adr_i, IOPW_OFF_DIR) && wb_sel_i[0]) begin
        cfg_d.dir = wb_dat_i[IOPW_NPINS-1:0]; // R05
      end
      if (hit(wb_adr_i, IOPW_OFF_DRAIN) && wb_sel_i[0]) begin
        cfg_d.drain = wb_dat_i[IOPW_NPINS-1:0];
      end
      if (hit(wb_adr_i, IOPW_OFF_INV) && wb_sel_i[0]) begin
        cfg_d.inv = wb_dat_i[IOPW_NPINS-1:0];
      end
      if (hit(wb_adr_i, IOPW_OFF_OUT) && wb_sel_i[0]) begin
        cfg_d.out = wb_dat_i[IOPW_NPINS-1:0];
      end
      if (hit(wb_adr_i, IOPW_OFF_LED) && wb_sel_i[0]) begin
        led_d = wb_dat_i[IOPW_NLEDS-1:0]; // R08
      end
      if (hit(wb_adr_i, IOPW_OFF_TIMEOUT)) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b]) begin
            tmo_d[8*b +: 8] = wb_dat_i[8*b +: 8]; // R10
          end
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_q <= IOPW_CFG_RST;
      led_q <= IOPW_LED_RST;
      tmo_q <= BITE_BITE_TIMEOUT;
    end else begin
      cfg_q <= cfg_d;
      led_q <= led_d;
      tmo_q <= tmo_d;
    end
  end

  assign led_o = led_q;

  // ****************************************
  // watchdog
  // ****************************************
  iopw_wdog u_wdog (
    .clock          (clock),
    .rst            (rst),
    .access         (take), // R09
    .pet            (wd_pet),
    .clear          (wd_clear),
    .timeout_cycles (wd_cycles),
    .bitten         (wd_bitten),
    .awake          (wd_awake)
  );

  // ****************************************
  // pin drivers
  // ****************************************
  for (genvar g = 0; g < IOPW_NPINS; g++) begin : g_pin
    // claimed pins take direction and value from their module
    assign eff_dir[g] = mod_claim[g] ? mod_dir[g] : cfg_q.dir[g]; // R06
    assign eff_val[g] = mod_claim[g] ? mod_out[g] : cfg_q.out[g]; // R06
    assign drv[g]     = eff_val[g] ^ cfg_q.inv[g]; // R02
    // bite or input: released; drain: release on one; else drive
    assign oe_n_d[g]  = (wd_bitten || !eff_dir[g]) ? 1'b1 : // R01 R04 R12
                        cfg_q.drain[g] ? drv[g] : 1'b0; // R03
    assign pin_o_d[g] = (!wd_bitten && eff_dir[g] && !cfg_q.drain[g]) ?
                        drv[g] : 1'b0; // R02
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pin_o_q <= '0;
      oe_n_q  <= '1;
      in_q    <= '0;
    end else begin
      pin_o_q <= pin_o_d;
      oe_n_q  <= oe_n_d;
      in_q    <= pin_i; // R13
    end
  end

  assign pin_o    = pin_o_q;
  assign pin_oe_n = oe_n_q;
  assign mod_in   = in_q; // R13

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_input_released;
    !wd_bitten |=> ((~$past(eff_dir) & ~pin_oe_n) == '0);
  endproperty
  a_input_released: assert property (p_input_released) // R01
    else $error("input pin is being driven");

  property p_pushpull;
    !wd_bitten |=> ((($past(eff_dir) & ~$past(cfg_q.drain)) &
                     (pin_oe_n | (pin_o ^ $past(drv)))) == '0);
  endproperty
  a_pushpull: assert property (p_pushpull) // R02
    else $error("push-pull pin not driving the selected value");

  property p_open_drain;
    !wd_bitten |=> ((($past(eff_dir) & $past(cfg_q.drain)) &
                     ((pin_oe_n ^ $past(drv)) | pin_o)) == '0);
  endproperty
  a_open_drain: assert property (p_open_drain) // R03
    else $error("open-drain pin wrong");

  property p_input_ignores;
    (!wd_bitten && (~eff_dir & (cfg_q.drain | cfg_q.inv)) != '0)
      |=> ((~$past(eff_dir) & pin_o) == '0);
  endproperty
  a_input_ignores: assert property (p_input_ignores) // R04
    else $error("drain or invert acted on an input pin");

  property p_claim_dir;
    !wd_bitten |=> (($past(mod_claim) & ~$past(cfg_q.drain) &
                     ($past(mod_dir) ^ ~pin_oe_n)) == '0);
  endproperty
  a_claim_dir: assert property (p_claim_dir) // R06
    else $error("claimed pin ignores module direction");

  property p_bite_release;
    wd_bitten |=> (pin_oe_n == '1 && pin_o == '0);
  endproperty
  a_bite_release: assert property (p_bite_release) // R12
    else $error("pin still driven after bite");

  property p_mod_in;
    // in_q follows pin_i one edge late, from the first edge after release
    !rst |=> (mod_in == $past(pin_i));
  endproperty
  a_mod_in: assert property (p_mod_in) // R13
    else $error("module input not tracking pin");

  sequence s_led_wr;
    req && wb_we_i && ack_q && !wd_bitten && wb_sel_i[0] &&
      hit(wb_adr_i, IOPW_OFF_LED);
  endsequence
  property p_led_write;
    s_led_wr |=> (led_o == $past(wb_dat_i[IOPW_NLEDS-1:0]));
  endproperty
  a_led_write: assert property (p_led_write) // R08
    else $error("led bits not updated by write");

  sequence s_in_rd;
    req && !ack_q && !wd_bitten && hit(wb_adr_i, IOPW_OFF_IN);
  endsequence
  property p_in_read;
    s_in_rd |=> (wb_ack_o && wb_dat_o[15:0] == {~$past(in_q), $past(in_q)});
  endproperty
  a_in_read: assert property (p_in_read) // R07
    else $error("input readback not true and complement");

  property p_recover_cfg;
    $fell(wd_bitten) |-> (cfg_q == IOPW_CFG_RST);
  endproperty
  a_recover_cfg: assert property (p_recover_cfg) // R15
    else $error("config not restored after recovery");

endmodule

/* File: pkg/iopw_pkg.sv */
// constants, types and helpers shared by the io pin block
package iopw_pkg;

  // ****************************************
  // sizes and timing
  // ****************************************
  localparam int          IOPW_NPINS         = 8;
  localparam int          IOPW_NLEDS         = 4;
  localparam int          IOPW_CLK_PERIOD_NS = 8;
  localparam logic [31:0] IOPW_BITE_TIMEOUT    = 32'h004C_4B40;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] IOPW_OFF_DIR     = 8'h00;
  localparam logic [7:0] IOPW_OFF_DRAIN   = 8'h04;
  localparam logic [7:0] IOPW_OFF_INV     = 8'h08;
  localparam logic [7:0] IOPW_OFF_OUT     = 8'h0C;
  localparam logic [7:0] IOPW_OFF_IN      = 8'h10;
  localparam logic [7:0] IOPW_OFF_LED     = 8'h14;
  localparam logic [7:0] IOPW_OFF_TIMEOUT = 8'h18;
  localparam logic [7:0] IOPW_OFF_STATUS  = 8'h1C;
  localparam logic [7:0] IOPW_OFF_SERVICE = 8'h20;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int         IOPW_IN_NOT_LSB  = 8;
  localparam int         IOPW_ST_BITTEN   = 0;
  localparam int         IOPW_ST_AWAKE    = 1;
  localparam logic [3:0] IOPW_LED_RST     = 4'h0;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    IOPW_WD_SLEEP  = 2'b00,
    IOPW_WD_RUN    = 2'b01,
    IOPW_WD_BITTEN = 2'b11
  } iopw_wd_e;

  typedef struct packed {
    logic [IOPW_NPINS-1:0] dir;
    logic [IOPW_NPINS-1:0] drain;
    logic [IOPW_NPINS-1:0] inv;
    logic [IOPW_NPINS-1:0] out;
  } iopw_cfg_s;

  localparam iopw_cfg_s IOPW_CFG_RST = '0;

  // longest time, so round down, but never below one cycle
  function automatic logic [31:0] iopw_ns_to_cycles(input logic [31:0] ns);
    logic [31:0] c;
    c = ns / 32'(IOPW_CLK_PERIOD_NS);
    return (c == 32'h0) ? 32'h1 : c;
  endfunction

endpackage

/* File: design/iopw_wdog.sv */
// host watchdog: sleeps until first access, counts down, bites
module iopw_wdog
  import iopw_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // host events
  input  wire logic        access,
  input  wire logic        pet,
  input  wire logic        clear,
  input  wire logic [31:0] timeout_cycles,
  // status
  output logic             bitten,
  output logic             awake
);

  iopw_wd_e    st_q;
  iopw_wd_e    st_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    case (st_q)
      IOPW_WD_SLEEP: begin
        if (access) begin
          st_d  = IOPW_WD_RUN; // R09
          cnt_d = timeout_cycles;
        end
      end
      IOPW_WD_RUN: begin
        // a service in the last cycle still counts as in time
        if (pet) begin
          cnt_d = timeout_cycles; // R11
        end else if (cnt_q <= 32'h1) begin
          st_d  = IOPW_WD_BITTEN; // R10
          cnt_d = 32'h0;
        end else begin
          cnt_d = cnt_q - 32'h1; // R16
        end
      end
      IOPW_WD_BITTEN: begin
        // clear only acts here, so a fresh bite always wins
        if (clear) begin
          st_d  = IOPW_WD_RUN; // R15
          cnt_d = timeout_cycles;
        end
      end
      default: begin
        st_d  = IOPW_WD_SLEEP;
        cnt_d = 32'h0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q  <= IOPW_WD_SLEEP;
      cnt_q <= 32'h0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  assign bitten = (st_q == IOPW_WD_BITTEN); // R14
  assign awake  = (st_q != IOPW_WD_SLEEP);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_sleep_stays;
    (st_q == IOPW_WD_SLEEP && !access) |=> (st_q == IOPW_WD_SLEEP && !bitten);
  endproperty
  a_sleep_stays: assert property (p_sleep_stays) // R09
    else $error("watchdog left sleep without host access");

  property p_pet_reload;
    (st_q == IOPW_WD_RUN && pet) |=>
      (cnt_q == $past(timeout_cycles) && !bitten);
  endproperty
  a_pet_reload: assert property (p_pet_reload) // R11
    else $error("service did not reload the countdown");

  property p_expire;
    (st_q == IOPW_WD_RUN && !pet && cnt_q == 32'h1) |=> bitten;
  endproperty
  a_expire: assert property (p_expire) // R16
    else $error("countdown reached zero without a bite");

  property p_bite_sticks;
    (bitten && !clear) |=> bitten;
  endproperty
  a_bite_sticks: assert property (p_bite_sticks) // R14
    else $error("bitten flag dropped without a clear");

  property p_clear_resumes;
    (bitten && clear) |=> (!bitten && cnt_q == $past(timeout_cycles));
  endproperty
  a_clear_resumes: assert property (p_clear_resumes) // R15
    else $error("clear did not restart the watchdog");

endmodule

/* File: test/iopw_host.sv */
// host-side bus master model for the io pin block
module iopw_host
  import iopw_pkg::*;
(
  // clock
  input  wire logic        clock,
  // wishbone master
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic      [7:0]  wb_adr_o,
  output logic      [3:0]  wb_sel_o,
  output logic      [31:0] wb_dat_o,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_ack_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // bus cycles
  // ****************************************
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o  = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
  end

  // caller enters right after a rising edge; no wait count assumed
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= w;
    wb_adr_o <= a;
    wb_sel_o <= 4'hF;
    wb_dat_o <= d;
    do @(posedge clock); while (wb_ack_i !== 1'b1);
    q = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o  <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask

  // any write to service outside a bite restarts the full countdown
  task automatic pet();
    wr(IOPW_OFF_SERVICE, 32'h0);
  endtask

  // bit0 low clears the bitten flag
  task automatic unbite();
    wr(IOPW_OFF_STATUS, 32'h0);
  endtask
endmodule

/* File: test/testbench.sv */
// self-checking bench for the io pin block
module testbench
  import iopw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // signals
  // ****************************************
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_wdat, wb_rdat, q;
  logic [7:0]  mod_claim = 8'h00;
  logic [7:0]  mod_dir = 8'h00;
  logic [7:0]  mod_out = 8'h00;
  logic [7:0]  mod_in, pin_i, pin_o, pin_oe_n;
  logic [7:0]  ext_en = 8'h00;
  logic [7:0]  ext_val = 8'h00;
  logic [3:0]  led_o;
  logic        wd_bitten;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  always #4 clock = ~clock;

  // released pads float high through the board pull-up
  assign pin_i = (~pin_oe_n & pin_o)
               | (pin_oe_n & ((ext_en & ext_val) | ~ext_en));

  iopw_top u_iopw_top (
    .clock     (clock),
    .rst       (rst),
    .wb_cyc_i  (wb_cyc),
    .wb_stb_i  (wb_stb),
    .wb_we_i   (wb_we),
    .wb_adr_i  (wb_adr),
    .wb_sel_i  (wb_sel),
    .wb_dat_i  (wb_wdat),
    .wb_dat_o  (wb_rdat),
    .wb_ack_o  (wb_ack),
    .mod_claim (mod_claim),
    .mod_dir   (mod_dir),
    .mod_out   (mod_out),
    .mod_in    (mod_in),
    .pin_i     (pin_i),
    .pin_o     (pin_o),
    .pin_oe_n  (pin_oe_n),
    .led_o     (led_o),
    .wd_bitten (wd_bitten)
  );

  iopw_host u_iopw_host (
    .clock    (clock),
    .wb_cyc_o (wb_cyc),
    .wb_stb_o (wb_stb),
    .wb_we_o  (wb_we),
    .wb_adr_o (wb_adr),
    .wb_sel_o (wb_sel),
    .wb_dat_o (wb_wdat),
    .wb_dat_i (wb_rdat),
    .wb_ack_i (wb_ack)
  );

  // ****************************************
  // helpers
  // ****************************************
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // a hung handshake must not stall the run
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic chk(input string n, input logic [31:0] g, e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask

  // checks right after an edge see the settled pre-edge values
  task automatic edges(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic cfg(input logic [31:0] d, r, i, o);
    u_iopw_host.wr(IOPW_OFF_DIR, d);
    u_iopw_host.wr(IOPW_OFF_DRAIN, r);
    u_iopw_host.wr(IOPW_OFF_INV, i);
    u_iopw_host.wr(IOPW_OFF_OUT, o);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    edges(20);
    chk("asleep", 32'(wd_bitten), 32'h0);
    // status data is captured before this first access wakes the dog
    u_iopw_host.rd(IOPW_OFF_STATUS, q);
    chk("status asleep", q, 32'h0);
    for (int k = 0; k < 4; k++) begin
      u_iopw_host.rd(8'(k * 4), q);
      chk("cfg rst", q, 32'h0);
    end
    u_iopw_host.rd(IOPW_OFF_TIMEOUT, q);
    chk("timeout rst", q, IOPW_BITE_TIMEOUT);
    u_iopw_host.rd(IOPW_OFF_STATUS, q);
    chk("status awake", q, 32'h2);
    u_iopw_host.wr(8'h3C, 32'hFFFF_FFFF);
    u_iopw_host.rd(8'h3C, q);
    chk("unmapped", q, 32'h0);
    $display("done reset");
  endtask

  task automatic t_input();
    ext_en  <= 8'hFF;
    ext_val <= 8'hA5;
    cfg(32'h00, 32'hFF, 32'hFF, 32'hFF);
    edges(2);
    chk("in oe_n", 32'(pin_oe_n), 32'hFF);
    chk("in mod_in", 32'(mod_in), 32'hA5);
    u_iopw_host.rd(IOPW_OFF_IN, q);
    chk("in level", 32'(q[15:0]), 32'h5AA5);
    $display("done input");
  endtask

  task automatic t_push();
    ext_en <= 8'h00;
    cfg(32'hFF, 32'h00, 32'h0F, 32'h33);
    edges(1);
    chk("pp oe_n", 32'(pin_oe_n), 32'h00);
    chk("pp out", 32'(pin_o), 32'h3C);
    $display("done push-pull");
  endtask

  task automatic t_drain();
    ext_en  <= 8'h01;
    ext_val <= 8'h00;
    cfg(32'hFF, 32'hFF, 32'h00, 32'h0F);
    edges(1);
    chk("od oe_n", 32'(pin_oe_n), 32'h0F);
    chk("od out", 32'(pin_o), 32'h00);
    u_iopw_host.rd(IOPW_OFF_IN, q);
    chk("od level", 32'(q[15:0]), 32'hF10E);
    $display("done drain");
  endtask

  task automatic t_claim();
    ext_en    <= 8'h0F;
    ext_val   <= 8'h05;
    mod_claim <= 8'hFF;
    mod_dir   <= 8'hF0;
    mod_out   <= 8'hA0;
    cfg(32'h00, 32'h80, 32'h30, 32'hFF);
    edges(2);
    chk("cl oe_n", 32'(pin_oe_n), 32'h8F);
    chk("cl out", 32'(pin_o), 32'h10);
    chk("cl mod_in", 32'(mod_in), 32'h95);
    mod_claim <= 8'h00;
    $display("done claim");
  endtask

  task automatic t_led();
    u_iopw_host.wr(IOPW_OFF_LED, 32'h5);
    edges(1);
    chk("led 5", 32'(led_o), 32'h5);
    u_iopw_host.wr(IOPW_OFF_LED, 32'hA);
    edges(1);
    chk("led a", 32'(led_o), 32'hA);
    u_iopw_host.rd(IOPW_OFF_LED, q);
    chk("led rd", q, 32'hA);
    $display("done led");
  endtask

  // 80 ns at 8 ns a cycle gives a ten-cycle countdown
  task automatic t_wdog();
    ext_en <= 8'h00;
    cfg(32'hFF, 32'h00, 32'h00, 32'h00);
    u_iopw_host.wr(IOPW_OFF_TIMEOUT, 32'h50);
    u_iopw_host.pet();
    edges(5);
    u_iopw_host.pet();
    edges(9);
    chk("no bite", 32'(wd_bitten), 32'h0);
    edges(1);
    chk("bite", 32'(wd_bitten), 32'h1);
    edges(1);
    chk("bit oe_n", 32'(pin_oe_n), 32'hFF);
    ext_en  <= 8'hFF;
    ext_val <= 8'h3C;
    u_iopw_host.rd(IOPW_OFF_DIR, q);
    chk("bit rd", q, 32'h0);
    u_iopw_host.rd(IOPW_OFF_STATUS, q);
    chk("bit flag", 32'(q[0]), 32'h1);
    chk("bit mod_in", 32'(mod_in), 32'h3C);
    // writes other than the status clear are dropped while bitten; led state survives the bite
    u_iopw_host.wr(IOPW_OFF_LED, 32'h5);
    edges(1);
    chk("bit led", 32'(led_o), 32'hA);
    u_iopw_host.unbite();
    edges(1);
    chk("cleared", 32'(wd_bitten), 32'h0);
    u_iopw_host.rd(IOPW_OFF_STATUS, q);
    chk("clr flag", 32'(q[0]), 32'h0);
    u_iopw_host.rd(IOPW_OFF_DIR, q);
    chk("clr cfg", q, 32'h0);
    $display("done watchdog");
  endtask

  initial begin
    edges(2);
    rst <= 1'b0;
    t_reset();
    t_input();
    t_push();
    t_drain();
    t_claim();
    t_led();
    t_wdog();
    end_sim();
  end
endmodule
